/* verilog/sbc_port.v */
// Functional notes
// - drive 26-bit card address, drive and receive 16-bit card data.
// - even byte enable selects even bytes, odd byte enable odd bytes.
// - card grounds both detects; both low means card present.
// - battery: both high good, two low weak, one low failed.
// - when enabled in i/o mode, modem call alert passes through to its output.
// - card audio taken only in i/o mode; sockets combined on speaker.
// - io read strobe asserted during host i/o reads.
// - io write strobe driven low during host i/o writes.
// - output enable strobe driven low during host memory reads.
// - dma card-to-host uses io read; host-to-card uses io write.
// - dma card-to-host signals terminal count on output enable.
// - dma request taken from battery detect two or input ack.
// - attribute select high for common, low for attr, i/o, dma.
// - dma host-to-card signals terminal count on write enable.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"

module sbc_port (
  input  wire                    ref_clk_i,              // core clock
  input  wire                    rst_i,                  // async reset, high
  // configuration
  input  wire                    cfg_io_mode_i,          // i/o interface mode
  input  wire                    cfg_ring_en_i,          // forward call alert
  input  wire                    cfg_spk_en_i,           // forward card audio
  input  wire                    cfg_dma_en_i,           // dma request enable
  input  wire                    cfg_dma_sel_i,          // 1: input ack is dreq
  input  wire                    peer_audio_i,           // other socket audio
  // host request side
  input  wire                    req_valid_i,            // access request
  output wire                    req_ready_o,            // request accepted
  input  wire [1:0]              req_type_i,             // access type
  input  wire                    req_write_i,            // write / dma to card
  input  wire                    req_tc_i,               // last dma transfer
  input  wire [`SBC_ADDR_W-1:0]  req_addr_i,             // card address
  input  wire [`SBC_DATA_W-1:0]  req_wdata_i,            // write data
  input  wire                    req_even_i,             // even byte wanted
  input  wire                    req_odd_i,              // odd byte wanted
  output reg                     rsp_valid_o,            // access done pulse
  output reg  [`SBC_DATA_W-1:0]  rsp_rdata_o,            // read data
  output reg                     rsp_ack_o,              // input ack seen
  // card pins
  output reg  [`SBC_ADDR_W-1:0]  card_addr_o,            // address lines
  input  wire [`SBC_DATA_W-1:0]  card_data_i,            // data lines in
  output reg  [`SBC_DATA_W-1:0]  card_data_o,            // data lines out
  output reg                     card_data_oe_o,         // data drive enable
  output wire                    even_byte_enable_n_o,   // even byte enable
  output wire                    odd_byte_enable_n_o,    // odd byte enable
  output wire                    output_enable_n_o,      // output enable / tc
  output wire                    write_enable_n_o,       // write enable / tc
  output wire                    io_read_strobe_n_o,     // i/o read strobe
  output wire                    io_write_strobe_n_o,    // i/o write strobe
  output wire                    attribute_select_n_o,   // attr select / dma_acknowledge
  input  wire                    card_detect_one_n_i,    // detect one
  input  wire                    card_detect_two_n_i,    // detect two
  input  wire                    battery_detect_one_i,   // bvd one / status_change
  input  wire                    battery_detect_two_i,   // bvd two / audio
  input  wire                    ready_i,                // ready / irq, low
  input  wire                    cycle_extend_n_i,       // wait, low
  input  wire                    input_ack_n_i,          // input ack, low
  // system side status
  output wire                    card_present_o,         // card in socket
  output wire                    card_inserted_o,        // insertion pulse
  output wire                    card_removed_o,         // removal pulse
  output wire [1:0]              batt_state_o,           // battery condition
  output wire                    status_change_o,        // status change pulse
  output reg                     card_ready_o,           // memory card ready
  output reg                     card_interrupt_req_o,   // i/o card irq
  output reg                     dma_request_o,          // dma request
  output reg                     modem_call_alert_out_o, // call alert out
  output reg                     speaker_out_o           // speaker audio
);

  // ****************************************************************
  // states and counts
  // ****************************************************************
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;

  localparam [7:0] SETUP_LAST  = `SBC_SETUP_CYC - 1;
  localparam [7:0] STROBE_LAST = `SBC_STROBE_CYC - 1;
  localparam [7:0] HOLD_LAST   = `SBC_HOLD_CYC - 1;

  reg [2:0]             state_q;
  reg [7:0]             cnt_q;
  reg [1:0]             type_q;
  reg                   write_q;
  reg                   tc_q;
  reg                   ce_even_q;
  reg                   ce_odd_q;
  reg                   attr_q;
  reg [3:0]             strb_q;   // {oe, we, ior, iow}, active high
  wire [`SBC_STAT_W-1:0] raw_stat;
  wire [`SBC_STAT_W-1:0] clean_stat;
  wire                  wr_any;

  // ****************************************************************
  // strobe decode
  // ****************************************************************
  function [3:0] sbc_strobes;
    input [1:0] typ;
    input       wr;
    input       tc;
    begin
      case (typ)
        `SBC_ACC_COMMON, `SBC_ACC_ATTR: begin
          // memory: oe reads, we writes
          sbc_strobes = wr ? 4'h4 : 4'h8;
        end
        `SBC_ACC_IO: begin
          sbc_strobes = wr ? 4'h1 : 4'h2;
        end
        `SBC_ACC_DMA: begin
          // host-to-card: iow, tc on we; card-to-host: ior, tc on oe
          sbc_strobes = wr ? {1'b0, tc, 2'h1}
                           : {tc, 3'h2};
        end
        default: begin
          sbc_strobes = 4'h0;
        end
      endcase
    end
  endfunction

  // ****************************************************************
  // status filtering
  // ****************************************************************
  assign raw_stat = {ready_i, battery_detect_two_i, battery_detect_one_i,
                     card_detect_two_n_i, card_detect_one_n_i};

  sbc_debounce u_debounce (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .raw_i     (raw_stat),
    .clean_o   (clean_stat)
  );

  sbc_status u_status (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .clean_i    (clean_stat),
    .io_mode_i  (cfg_io_mode_i),
    .present_o  (card_present_o),
    .inserted_o (card_inserted_o),
    .removed_o  (card_removed_o),
    .batt_o     (batt_state_o),
    .chg_o      (status_change_o)
  );

  // ****************************************************************
  // card strobes and enables (active low on the pins)
  // ****************************************************************
  assign wr_any               = strb_q[2] | strb_q[0];
  assign output_enable_n_o    = ~(strb_q[3] & ~wr_any);
  assign io_read_strobe_n_o   = ~(strb_q[1] & ~wr_any);
  assign write_enable_n_o     = ~strb_q[2];
  assign io_write_strobe_n_o  = ~strb_q[0];
  assign even_byte_enable_n_o = ~ce_even_q;
  assign odd_byte_enable_n_o  = ~ce_odd_q;
  assign attribute_select_n_o = ~attr_q;

  // idle with a card present
  assign req_ready_o = (state_q == ST_IDLE) & card_present_o;

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q        <= ST_IDLE;
      cnt_q          <= 8'h00;
      type_q         <= `SBC_ACC_COMMON;
      write_q        <= 1'b0;
      tc_q           <= 1'b0;
      ce_even_q      <= 1'b0;
      ce_odd_q       <= 1'b0;
      attr_q         <= 1'b0;
      strb_q         <= 4'h0;
      card_addr_o    <= `SBC_RST_ADDR;
      card_data_o    <= `SBC_RST_DATA;
      card_data_oe_o <= 1'b0;
      rsp_valid_o    <= 1'b0;
      rsp_rdata_o    <= `SBC_RST_DATA;
      rsp_ack_o      <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i && card_present_o) begin
            type_q         <= req_type_i;
            write_q        <= req_write_i;
            tc_q           <= req_tc_i;
            card_addr_o    <= req_addr_i;
            card_data_o    <= req_wdata_i;
            card_data_oe_o <= req_write_i;
            ce_even_q      <= req_even_i;
            ce_odd_q       <= req_odd_i;
            // high for common memory, low for attr, i/o and dma_acknowledge
            attr_q         <= (req_type_i != `SBC_ACC_COMMON);
            rsp_ack_o      <= 1'b0;
            cnt_q          <= SETUP_LAST;
            state_q        <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_q == 8'h00) begin
            strb_q  <= sbc_strobes(type_q, write_q, tc_q);
            cnt_q   <= STROBE_LAST;
            state_q <= ST_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_STROBE: begin
          // input ack during i/o read
          if (strb_q[1] && !input_ack_n_i) begin
            rsp_ack_o <= 1'b1;
          end
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (cycle_extend_n_i) begin
            // sample data, close strobe
            rsp_rdata_o <= card_data_i;
            strb_q      <= 4'h0;
            cnt_q       <= HOLD_LAST;
            state_q     <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_q == 8'h00) begin
            ce_even_q      <= 1'b0;
            ce_odd_q       <= 1'b0;
            attr_q         <= 1'b0;
            card_data_oe_o <= 1'b0;
            rsp_valid_o    <= 1'b1;
            state_q        <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          strb_q  <= 4'h0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // side-band signals
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      card_ready_o           <= 1'b0;
      card_interrupt_req_o   <= 1'b0;
      dma_request_o          <= 1'b0;
      modem_call_alert_out_o <= 1'b0;
      speaker_out_o          <= 1'b0;
    end else begin
      // ready in memory mode, irq in i/o mode
      card_ready_o         <= card_present_o & ~cfg_io_mode_i &
                              clean_stat[`SBC_ST_RDY];
      card_interrupt_req_o <= card_present_o & cfg_io_mode_i &
                              ~ready_i;
      // dma request: low input ack or high bvd two
      dma_request_o        <= cfg_dma_en_i & card_present_o &
                              (cfg_dma_sel_i ? ~input_ack_n_i
                                             : battery_detect_two_i);
      // low call alert forwarded high
      modem_call_alert_out_o <= cfg_ring_en_i & cfg_io_mode_i &
                                card_present_o &
                                ~battery_detect_one_i;
      // i/o-mode audio xored with the other socket
      speaker_out_o <= (cfg_spk_en_i & cfg_io_mode_i & card_present_o &
                        battery_detect_two_i) ^ peer_audio_i;
    end
  end

endmodule
`default_nettype wire

/* verilog/sbc_defs.vh */
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH

// ****************************************************************
// clock and access timing
// ****************************************************************
`define SBC_CLK_NS        4
`define SBC_SETUP_NS      30
`define SBC_STROBE_NS     100
`define SBC_HOLD_NS       20
`define SBC_DEBOUNCE_NS   2000
// least times, rounded up to whole cycles
`define SBC_SETUP_CYC     ((`SBC_SETUP_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_STROBE_CYC    ((`SBC_STROBE_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_HOLD_CYC      ((`SBC_HOLD_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_DEBOUNCE_CYC  ((`SBC_DEBOUNCE_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)

// ****************************************************************
// widths
// ****************************************************************
`define SBC_ADDR_W        26
`define SBC_DATA_W        16
`define SBC_STAT_W        5

// ****************************************************************
// access types
// ****************************************************************
`define SBC_ACC_COMMON    2'h0
`define SBC_ACC_ATTR      2'h1
`define SBC_ACC_IO        2'h2
`define SBC_ACC_DMA       2'h3

// ****************************************************************
// battery condition codes
// ****************************************************************
`define SBC_BATT_GOOD     2'h0
`define SBC_BATT_WEAK     2'h1
`define SBC_BATT_FAILED   2'h2

// ****************************************************************
// positions in the filtered status vector
// ****************************************************************
`define SBC_ST_CD1        0
`define SBC_ST_CD2        1
`define SBC_ST_BATTERY_DETECT_ONE       2
`define SBC_ST_BATTERY_DETECT_TWO       3
`define SBC_ST_RDY        4

// ****************************************************************
// reset values
// ****************************************************************
`define SBC_RST_STAT      5'h1F
`define SBC_RST_ADDR      26'h0000000
`define SBC_RST_DATA      16'h0000

`endif

/* verilog/sbc_debounce.v */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"

module sbc_debounce (
  input  wire                    ref_clk_i, // core clock
  input  wire                    rst_i,     // async reset, high
  input  wire [`SBC_STAT_W-1:0]  raw_i,     // raw status pins
  output wire [`SBC_STAT_W-1:0]  clean_o    // filtered levels
);

  localparam [11:0] DB_LAST = `SBC_DEBOUNCE_CYC - 1;

  genvar g;
  generate
    for (g = 0; g < `SBC_STAT_W; g = g + 1) begin : bit_g
      reg        samp_q;
      reg        stab_q;
      reg [11:0] cnt_q;
      // take a level once held a whole window
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          samp_q <= 1'b1;
          stab_q <= 1'b1;
          cnt_q  <= 12'h000;
        end else begin
          samp_q <= raw_i[g];
          if (samp_q == stab_q) begin
            cnt_q <= 12'h000;
          end else if (cnt_q == DB_LAST) begin
            stab_q <= samp_q;
            cnt_q  <= 12'h000;
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
      end
      assign clean_o[g] = stab_q;
    end
  endgenerate

endmodule
`default_nettype wire

/* verilog/sbc_status.v */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"

module sbc_status (
  input  wire                    ref_clk_i,   // core clock
  input  wire                    rst_i,       // async reset, high
  input  wire [`SBC_STAT_W-1:0]  clean_i,     // filtered status
  input  wire                    io_mode_i,   // socket in i/o mode
  output wire                    present_o,   // card in socket
  output reg                     inserted_o,  // insertion pulse
  output reg                     removed_o,   // removal pulse
  output reg  [1:0]              batt_o,      // battery condition
  output reg                     chg_o        // status change pulse
);

  reg present_q;
  reg battery_detect_one_q;

  // both detects low: card present
  assign present_o = ~clean_i[`SBC_ST_CD1] & ~clean_i[`SBC_ST_CD2];

  // ****************************************************************
  // battery decode
  // ****************************************************************
  always @* begin
    if (!clean_i[`SBC_ST_BATTERY_DETECT_ONE]) begin
      batt_o = `SBC_BATT_FAILED;
    end else if (!clean_i[`SBC_ST_BATTERY_DETECT_TWO]) begin
      batt_o = `SBC_BATT_WEAK;
    end else begin
      batt_o = `SBC_BATT_GOOD;
    end
  end

  // ****************************************************************
  // event pulses
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      present_q  <= 1'b0;
      battery_detect_one_q     <= 1'b1;
      inserted_o <= 1'b0;
      removed_o  <= 1'b0;
      chg_o      <= 1'b0;
    end else begin
      present_q  <= present_o;
      battery_detect_one_q     <= clean_i[`SBC_ST_BATTERY_DETECT_ONE];
      inserted_o <= present_o & ~present_q;
      removed_o  <= ~present_o & present_q;
      // falling bvd one reports a status change
      chg_o      <= io_mode_i & present_o &
                    battery_detect_one_q & ~clean_i[`SBC_ST_BATTERY_DETECT_ONE];
    end
  end

endmodule
`default_nettype wire

/* verification/sbc_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"
// ****************************************
// socket port checks
// ****************************************
module sbc_port_properties (
  input wire logic        ref_clk_i, // clock
  input wire logic        rst_i, // reset
  input wire logic        req_valid_i, // request
  input wire logic        req_ready_o, // accepted
  input wire logic [1:0]  req_type_i, // kind
  input wire logic        req_write_i, // write
  input wire logic        req_tc_i, // last dma
  input wire logic [25:0] req_addr_i, // address
  input wire logic        req_even_i, // even byte
  input wire logic        req_odd_i, // odd byte
  input wire logic [25:0] card_addr_o, // card address
  input wire logic        even_byte_enable_n_o, // even enable
  input wire logic        odd_byte_enable_n_o, // odd enable
  input wire logic        output_enable_n_o, // oe
  input wire logic        write_enable_n_o, // we
  input wire logic        io_read_strobe_n_o, // ior
  input wire logic        io_write_strobe_n_o, // iow
  input wire logic        attribute_select_n_o, // attr
  input wire logic        cycle_extend_n_i, // extend
  input wire logic        cfg_dma_en_i, // dma on
  input wire logic        cfg_dma_sel_i, // dreq pick
  input wire logic        input_ack_n_i, // input ack
  input wire logic        battery_detect_two_i, // bvd two
  input wire logic        dma_request_o, // dreq out
  input wire logic        card_present_o // card in
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // shared request decode
  wire take = req_valid_i & req_ready_o;
  wire rd   = take & !req_write_i;
  wire io   = req_type_i == `SBC_ACC_IO;
  wire dma  = req_type_i == `SBC_ACC_DMA;
  wire rds  = !io_read_strobe_n_o | !output_enable_n_o;
  wire wrs  = !io_write_strobe_n_o | !write_enable_n_o;
  wire strb = rds | wrs;
  AST_EXCL: assert property (!(rds && wrs))
    else $error("strobe overlap");
  AST_ADDR: assert property (take |=> card_addr_o == $past(req_addr_i))
    else $error("bad address");
  AST_BYTE: assert property (take |=> {even_byte_enable_n_o, odd_byte_enable_n_o} ==
    ~{$past(req_even_i), $past(req_odd_i)}) else $error("byte enables wrong");
  AST_NOCARD: assert property (!card_present_o |-> !req_ready_o)
    else $error("ready with no card");
  AST_IO_READ_STROBE: assert property (rd && io |-> ##[1:12] !io_read_strobe_n_o)
    else $error("no i/o read strobe");
  AST_MEMRD: assert property (rd && !req_type_i[1] |-> ##[1:12] !output_enable_n_o)
    else $error("no output enable");
  AST_DMATC: assert property (rd && dma && req_tc_i |->
    ##[1:12] !output_enable_n_o && !io_read_strobe_n_o) else $error("no dma count");
  AST_ATTR: assert property (take |=>
    attribute_select_n_o == ($past(req_type_i) == `SBC_ACC_COMMON)) else $error("attr wrong");
  AST_EXT: assert property (strb && !cycle_extend_n_i |=> strb)
    else $error("extend ignored");
  AST_DREQ: assert property (cfg_dma_en_i |=> dma_request_o ==
    ($past(cfg_dma_sel_i) ? !$past(input_ack_n_i) : $past(battery_detect_two_i)))
    else $error("dma request wrong");
  // main scenarios seen
  cover property (rd && io);
  cover property (strb && !cycle_extend_n_i);
  cover property (take && dma && req_tc_i);
endmodule
bind sbc_port sbc_port_properties sbc_port_properties_inst (.*);
`default_nettype wire

/* verification/sbc_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// behavioural card
// ****************************************
module sbc_card_model (
  input  wire logic        ref_clk_i, // clock
  input  wire logic        rst_i, // reset
  input  wire logic        present_i, // inserted
  input  wire logic [1:0]  bvd_i, // battery levels
  input  wire logic        dreq_i, // dma request
  input  wire logic        ack_en_i, // answer i/o reads
  input  wire logic [7:0]  ext_i, // strobe cycles held
  input  wire logic [25:0] addr_i, // address
  input  wire logic [15:0] wdata_i, // data wire
  input  wire logic        oe_n_i, // oe
  input  wire logic        we_n_i, // we
  input  wire logic        ior_n_i, // ior
  input  wire logic        iow_n_i, // iow
  output logic      [15:0] rdata_o, // card drive
  output logic             cd_n_o, // detects
  output logic             battery_detect_one_o, // battery one
  output logic             battery_detect_two_o, // battery two
  output logic             ready_o, // ready
  output logic             ext_n_o, // extend
  output logic             ack_n_o, // input ack
  output logic      [15:0] wcap_o // last write
);
  logic [15:0] last_q;
  logic [7:0]  cnt_q;
  wire rd   = !ior_n_i | !oe_n_i;
  wire strb = rd | !iow_n_i | !we_n_i;
  // card pins; released data reads inverted
  assign cd_n_o  = !present_i;
  assign battery_detect_one_o  = bvd_i[0];
  assign battery_detect_two_o  = bvd_i[1];
  assign ready_o = 1'b1;
  assign ack_n_o = !((ack_en_i & !ior_n_i) | dreq_i);
  assign ext_n_o = !(strb && cnt_q < ext_i);
  assign rdata_o = rd ? (addr_i[15:0] ^ 16'h5A3C) : ~last_q;
  // strobe count, last drive, write capture
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      last_q <= 16'h0000;
      wcap_o <= 16'h0000;
    end else begin
      cnt_q <= strb ? cnt_q + 8'h01 : 8'h00;
      if (rd)
        last_q <= rdata_o;
      if (!iow_n_i | !we_n_i)
        wcap_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

/* verification/sbc_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"
// ****************************************
// socket port bench
// ****************************************
module sbc_port_test;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, cfg_io_mode_i = 1'b1, cfg_ring_en_i = 1'b0;
  logic cfg_spk_en_i = 1'b0, cfg_dma_en_i = 1'b0, cfg_dma_sel_i = 1'b0, peer_audio_i = 1'b0;
  logic req_valid_i = 1'b0, req_write_i = 1'b0, req_tc_i = 1'b0, req_even_i = 1'b0;
  logic req_odd_i = 1'b0, present = 1'b0, dreq = 1'b0, ack_en = 1'b0;
  logic [1:0]  req_type_i = 2'h0, bvd = 2'h3, batt_state_o, prev;
  logic [7:0]  ext = 8'h00;
  logic [25:0] req_addr_i = 26'h0000000, card_addr_o;
  logic [15:0] req_wdata_i = 16'h0000, card_data_i, card_data_o, rsp_rdata_o, crd, wcap;
  logic [15:0] chg_cnt = 16'h0000, ins_cnt = 16'h0000, rem_cnt = 16'h0000;
  logic req_ready_o, rsp_valid_o, rsp_ack_o, card_data_oe_o, even_byte_enable_n_o;
  logic odd_byte_enable_n_o, output_enable_n_o, write_enable_n_o, io_read_strobe_n_o;
  logic io_write_strobe_n_o, attribute_select_n_o, card_detect_one_n_i, card_detect_two_n_i;
  logic battery_detect_one_i, battery_detect_two_i, ready_i, cycle_extend_n_i, input_ack_n_i;
  logic card_present_o, card_inserted_o, card_removed_o, status_change_o, card_ready_o;
  logic card_interrupt_req_o, dma_request_o, modem_call_alert_out_o, speaker_out_o;
  logic [17:0] exp_q [$];
  logic [17:0] note;
  int fails = 0, check_count = 0, cyc = 0;
  // access kinds {type, write, tc, ack}; battery steps {bvd two, bvd one}
  localparam logic [4:0] ACC [0:9] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h11,
                                       5'h14, 5'h1A, 5'h1E, 5'h18, 5'h10};
  localparam logic [1:0] BSEQ [0:3] = '{2'h1, 2'h2, 2'h0, 2'h3};
  // shared data wire and both detect pins
  assign card_data_i = card_data_oe_o ? card_data_o : crd;
  assign card_detect_two_n_i = card_detect_one_n_i;
  sbc_port sbc_port_inst (.*);
  sbc_card_model sbc_card_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .present_i(present),
    .bvd_i(bvd), .dreq_i(dreq), .ack_en_i(ack_en), .ext_i(ext), .addr_i(card_addr_o),
    .wdata_i(card_data_i), .oe_n_i(output_enable_n_o), .we_n_i(write_enable_n_o),
    .ior_n_i(io_read_strobe_n_o), .iow_n_i(io_write_strobe_n_o), .rdata_o(crd),
    .cd_n_o(card_detect_one_n_i), .battery_detect_one_o(battery_detect_one_i), .battery_detect_two_o(battery_detect_two_i),
    .ready_o(ready_i), .ext_n_o(cycle_extend_n_i), .ack_n_o(input_ack_n_i), .wcap_o(wcap));
  always #2 ref_clk_i = ~ref_clk_i;
  task end_sim;
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  localparam int CYC = `SBC_SETUP_CYC + `SBC_STROBE_CYC + `SBC_HOLD_CYC;
  // one access: note, request, time it
  task automatic access(input logic [4:0] k, input logic [7:0] e);
    logic [25:0] a;
    logic [15:0] d;
    int n;
    a = 26'($urandom);
    d = 16'($urandom);
    exp_q.push_back({k[2], k[0], (k[2] ? d : (a[15:0] ^ 16'h5A3C))});
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    {req_type_i, req_write_i, req_tc_i, ack_en} <= k;
    req_addr_i <= a;
    req_wdata_i <= d;
    {req_even_i, req_odd_i} <= 2'($urandom);
    ext <= e;
    n = 0;
    do @(posedge ref_clk_i); while (req_ready_o !== 1'b1 && ++n < 100);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 400);
    if (e == 8'h00)
      check(16'(n), 16'(CYC));
    else
      check(16'(n > CYC), 16'h0001);
  endtask
  // compare each result with the oldest note
  always @(posedge ref_clk_i) begin
    if (rsp_valid_o === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[17])
        check(wcap, note[15:0]);
      else
        check(rsp_rdata_o, note[15:0]);
      if (!note[17])
        check(16'(rsp_ack_o), 16'(note[16]));
    end
  end
  // status pulse counts and timeout
  always @(posedge ref_clk_i) begin
    chg_cnt <= chg_cnt + 16'(status_change_o === 1'b1);
    ins_cnt <= ins_cnt + 16'(card_inserted_o === 1'b1);
    rem_cnt <= rem_cnt + 16'(card_removed_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    void'($urandom(89));
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    req_valid_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    check(16'(req_ready_o), 16'h0000);
    req_valid_i <= 1'b0;
    present <= 1'b1;
    repeat (400) @(posedge ref_clk_i);
    check(16'(card_present_o), 16'h0000);
    repeat (120) @(posedge ref_clk_i);
    check(16'(card_present_o), 16'h0001);
    for (int i = 0; i < 10; i++) access(ACC[i], 8'h00);
    access(5'h11, 8'h28);
    prev = `SBC_BATT_GOOD;
    @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      bvd <= BSEQ[i];
      repeat (100) @(posedge ref_clk_i);
      check(16'(batt_state_o), 16'(prev));
      repeat (420) @(posedge ref_clk_i);
      prev = !BSEQ[i][0] ? `SBC_BATT_FAILED : (!BSEQ[i][1] ? `SBC_BATT_WEAK : `SBC_BATT_GOOD);
      check(16'(batt_state_o), 16'(prev));
    end
    check(chg_cnt, 16'h0001);
    repeat (300) begin
      @(posedge ref_clk_i);
      {cfg_io_mode_i, cfg_ring_en_i, cfg_spk_en_i, cfg_dma_en_i} <= 4'($urandom);
      {cfg_dma_sel_i, peer_audio_i, dreq, bvd} <= 5'($urandom);
    end
    @(posedge ref_clk_i);
    present <= 1'b0;
    bvd <= 2'h3;
    repeat (520) @(posedge ref_clk_i);
    check(16'(card_present_o), 16'h0000);
    check(ins_cnt, 16'h0001);
    check(rem_cnt, 16'h0001);
    end_sim();
  end
endmodule
`default_nettype wire
